//--- refresh_defines.svh
// Purpose: constants for the refresh and self-refresh engine
// Assumes: 125 MHz clock, 8 ns period
// Notes: refresh times kept in ns, their cycle counts derived from them; residence and exit defaults given directly in cycles
`ifndef REFRESH_DEFINES_SVH
`define REFRESH_DEFINES_SVH
// ==================================================
// timing
`define CLK_PERIOD_PS 8000
`define TRFC_AB_NS 130
`define TRFC_PB_NS 60
// least times round up to whole cycles
`define TRFC_AB_CYC ((`TRFC_AB_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TRFC_PB_CYC ((`TRFC_PB_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// internal refresh period in self-refresh (3.9 us average interval)
`define TREFI_NS 3900
`define TREFI_CYC ((`TREFI_NS * 1000) / `CLK_PERIOD_PS)
`define NUM_BANKS 8
`define CKESR_CYC_DEFAULT 16
`define XSR_CYC_DEFAULT 18
`endif

//--- refresh_pkg.sv
// Purpose: types for the refresh and self-refresh engine
// Assumes: nothing beyond the defines header
// Notes: gray-coded state along entry, reside, exit path
package refresh_pkg;
  // ==================================================
  // states
  typedef enum logic [1:0]
  {
    st_active = 2'b00,
    st_self_refresh = 2'b01,
    st_exit_recovery = 2'b11
  } mode_t;
endpackage : refresh_pkg

//--- lpddr2_refresh_self_refresh.sv
// Purpose: device-side refresh decode, bank pointer and self-refresh sequencing
// Assumes: command pins synchronous to clock; controller keeps its own spacing
// Notes: internal timer runs on the same clock; stopped-clock periods not modelled
//
// Contract
// - eight per-bank refreshes count as one all-bank refresh.
// - self-refresh entry: enable low, select low, bits 0,1 low, bit2 high.
// - in self-refresh ignore all inputs except clock enable; the code also reads hot there to set the internal period.
// - internal all-bank refresh within residence time; stay at least that long.
// - internal timer keeps data; activity scales with temperature.
// - refresh command decode; bit3 low per-bank, high all-bank.
// - bank pointer round-robin 0..7, zeroed on reset, exit, all-bank refresh.
// - exit recovery counted from first edge after enable goes high.
`timescale 1ns/10ps
`include "refresh_defines.svh"
module lpddr2_refresh_self_refresh
#(
  parameter int unsigned CKESR_CYC = `CKESR_CYC_DEFAULT,
  parameter int unsigned XSR_CYC = `XSR_CYC_DEFAULT
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic cmd_bit0,
  input wire logic cmd_bit1,
  input wire logic cmd_bit2,
  input wire logic cmd_bit3,
  input wire logic hot, // high temperature: internal refresh rate doubled
  output logic all_bank_refresh_cmd,
  output logic per_bank_refresh_cmd,
  output logic [2:0] refresh_bank,
  output logic in_self_refresh,
  output logic internal_clock_gate,
  output logic internal_refresh,
  output logic exit_recovery,
  output logic refresh_busy
);
  // ==================================================
  // state
  refresh_pkg::mode_t mode, next_mode;
  logic cke_prev, next_cke_prev;
  logic [2:0] bank_ptr, next_bank_ptr;
  logic [15:0] timer, next_timer;
  logic [15:0] resid, next_resid;
  logic [7:0] busy_cnt, next_busy_cnt;
  logic ref_seen, next_ref_seen;
  logic all_q, next_all_q;
  logic pb_q, next_pb_q;
  logic int_ref_q, next_int_ref_q;

  // decode shared by refresh and self-refresh entry
  function automatic logic ref_code(input logic sel_n, input logic b0, input logic b1,
                                    input logic b2);
    ref_code = !sel_n && !b0 && !b1 && b2;
  endfunction : ref_code

  logic code_hit, take_ab, take_pb, take_sre;
  logic [15:0] int_period;

  // ==================================================
  // command decode
  always_comb
  begin
    code_hit = ref_code(cs_n, cmd_bit0, cmd_bit1, cmd_bit2);
    take_ab = (mode == refresh_pkg::st_active) && cke && cke_prev && code_hit && cmd_bit3;
    take_pb = (mode == refresh_pkg::st_active) && cke && cke_prev && code_hit && !cmd_bit3;
    take_sre = (mode == refresh_pkg::st_active) && !cke && cke_prev && code_hit;
    // hotter die refreshes more often
    int_period = hot ? 16'((`TREFI_CYC) / 2) : 16'(`TREFI_CYC);
  end

  // ==================================================
  // next-state logic
  always_comb
  begin
    next_mode = mode;
    next_cke_prev = cke;
    next_bank_ptr = bank_ptr;
    next_timer = timer;
    next_resid = resid;
    next_busy_cnt = (busy_cnt != 8'h00) ? busy_cnt - 8'h01 : 8'h00;
    next_ref_seen = ref_seen;
    next_all_q = 1'b0;
    next_pb_q = 1'b0;
    next_int_ref_q = 1'b0;
    unique case (mode)
      refresh_pkg::st_active:
      begin
        if (take_ab)
        begin
          next_all_q = 1'b1;
          next_bank_ptr = 3'h0;
          next_busy_cnt = 8'(`TRFC_AB_CYC);
          next_ref_seen = 1'b1;
        end
        else if (take_pb)
        begin
          next_pb_q = 1'b1;
          next_bank_ptr = bank_ptr + 3'h1;
          next_busy_cnt = 8'(`TRFC_PB_CYC);
          // a full round of eight stands for one all-bank refresh
          if (bank_ptr == 3'h7)
          begin
            next_ref_seen = 1'b1;
          end
        end
        else if (take_sre)
        begin
          // first internal refresh fires at once, well inside residence
          next_mode = refresh_pkg::st_self_refresh;
          next_int_ref_q = 1'b1;
          next_busy_cnt = 8'(`TRFC_AB_CYC);
          next_timer = 16'h0000;
          next_resid = 16'h0000;
          next_ref_seen = 1'b0;
        end
      end
      refresh_pkg::st_self_refresh:
      begin
        // only cke and hot are looked at here; command pins are don't care
        if (resid != 16'hffff)
        begin
          next_resid = resid + 16'h0001;
        end
        if (timer + 16'h0001 >= int_period)
        begin
          next_timer = 16'h0000;
          next_int_ref_q = 1'b1;
          next_busy_cnt = 8'(`TRFC_AB_CYC);
        end
        else
        begin
          next_timer = timer + 16'h0001;
        end
        // exit refused until residence time has passed
        if (cke && (resid >= 16'(CKESR_CYC)))
        begin
          next_mode = refresh_pkg::st_exit_recovery;
          next_timer = 16'h0000;
          next_bank_ptr = 3'h0;
        end
      end
      refresh_pkg::st_exit_recovery:
      begin
        // counts from the first edge with cke high
        next_timer = timer + 16'h0001;
        if (!cke)
        begin
          // re-entry is a fresh stay: residence and first internal refresh restart
          next_mode = refresh_pkg::st_self_refresh; // re-entry
          next_timer = 16'h0000;
          next_resid = 16'h0000;
          next_int_ref_q = 1'b1;
          next_busy_cnt = 8'(`TRFC_AB_CYC);
        end
        else if (timer + 16'h0001 >= 16'(XSR_CYC))
        begin
          next_mode = refresh_pkg::st_active;
          next_timer = 16'h0000;
        end
      end
      default:
      begin
        next_mode = refresh_pkg::st_active;
      end
    endcase
  end

  // ==================================================
  // registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      mode <= refresh_pkg::st_active;
      cke_prev <= 1'b0;
      bank_ptr <= 3'h0;
      timer <= 16'h0000;
      resid <= 16'h0000;
      busy_cnt <= 8'h00;
      ref_seen <= 1'b1; // no stay yet, so nothing owed before a first entry
      all_q <= 1'b0;
      pb_q <= 1'b0;
      int_ref_q <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      cke_prev <= next_cke_prev;
      bank_ptr <= next_bank_ptr;
      timer <= next_timer;
      resid <= next_resid;
      busy_cnt <= next_busy_cnt;
      ref_seen <= next_ref_seen;
      all_q <= next_all_q;
      pb_q <= next_pb_q;
      int_ref_q <= next_int_ref_q;
    end
  end

  // pulses and bank straight from flip-flops; mode flags and busy decoded from registered state
  assign all_bank_refresh_cmd = all_q;
  assign per_bank_refresh_cmd = pb_q;
  assign refresh_bank = bank_ptr;
  assign in_self_refresh = (mode == refresh_pkg::st_self_refresh);
  assign internal_clock_gate = (mode == refresh_pkg::st_self_refresh);
  assign internal_refresh = int_ref_q;
  assign exit_recovery = (mode == refresh_pkg::st_exit_recovery);
  assign refresh_busy = (busy_cnt != 8'h00);

  // ==================================================
  // checks
  chk_entry_decode: assert property (@(posedge clock) disable iff (srst)
    take_sre |=> in_self_refresh && internal_refresh)
    else $error("self-refresh entry not taken");
  chk_ab_ptr_zero: assert property (@(posedge clock) disable iff (srst)
    take_ab |=> all_bank_refresh_cmd && refresh_bank == 3'h0)
    else $error("bank pointer not cleared by all-bank refresh");
  chk_pb_advance: assert property (@(posedge clock) disable iff (srst)
    take_pb |=> per_bank_refresh_cmd && refresh_bank == $past(bank_ptr) + 3'h1)
    else $error("bank pointer did not advance");
  // watches the pulses themselves, so a decode leak in self-refresh shows
  chk_sr_ignores_cmd: assert property (@(posedge clock) disable iff (srst)
    in_self_refresh |=> !all_bank_refresh_cmd && !per_bank_refresh_cmd)
    else $error("command decoded in self-refresh");
  chk_min_residence: assert property (@(posedge clock) disable iff (srst)
    in_self_refresh && !$past(in_self_refresh) |=> in_self_refresh [*8])
    else $error("left self-refresh too early");
  chk_exit_ptr_zero: assert property (@(posedge clock) disable iff (srst)
    $rose(exit_recovery) |-> refresh_bank == 3'h0)
    else $error("bank pointer not cleared on exit");
  chk_recovery_len: assert property (@(posedge clock) disable iff (srst)
    $rose(exit_recovery) && cke |-> ##[1:20] !exit_recovery)
    else $error("exit recovery did not end");
  chk_busy_ab: assert property (@(posedge clock) disable iff (srst)
    take_ab |=> refresh_busy [*8])
    else $error("all-bank busy too short");
  // a missed internal refresh at exit is only safe if one was sent since
  chk_ref_before_sre: assert property (@(posedge clock) disable iff (srst)
    take_sre |-> ref_seen)
    else $error("self-refresh entered with no refresh since last exit");
  cov_ab: cover property (@(posedge clock) take_ab);
  cov_pb_round: cover property (@(posedge clock) take_pb && bank_ptr == 3'h7);
  cov_sr_exit: cover property (@(posedge clock) $fell(exit_recovery) && cke);
  cov_reentry: cover property (@(posedge clock) $fell(exit_recovery) && in_self_refresh);
endmodule : lpddr2_refresh_self_refresh

//--- ctl_model.sv
// Purpose: controller model driving clock enable and command pins
// Assumes: pins change at the falling edge, sampled at the rising edge
// Notes: command bits are don't-care during a nop, so idle flips them each cycle; set_cke leaves them as they are
`timescale 1ns/10ps
module ctl_model
(
  input wire logic clock,
  output logic cke,
  output logic cs_n,
  output logic cmd_bit0,
  output logic cmd_bit1,
  output logic cmd_bit2,
  output logic cmd_bit3
);
  // ==================================================
  // idle levels at time zero
  initial
  begin
    cke = 1'b0;
    cs_n = 1'b1;
    {cmd_bit0, cmd_bit1, cmd_bit2, cmd_bit3} = 4'h0;
  end
  // nop cycles; bits inverted so a stale value is never mistaken for a command
  task automatic idle(input int n);
    repeat (n)
    begin
      @(negedge clock);
      cs_n = 1'b1;
      {cmd_bit0, cmd_bit1, cmd_bit2, cmd_bit3} = ~{cmd_bit0, cmd_bit1, cmd_bit2, cmd_bit3};
    end
  endtask : idle
  // refresh code; cke low turns it into self-refresh entry
  task automatic issue(input logic ce, input logic b3);
    @(negedge clock);
    cke = ce;
    cs_n = 1'b0;
    {cmd_bit0, cmd_bit1, cmd_bit2, cmd_bit3} = {3'b001, b3};
  endtask : issue
  // clock runs free, so two stable cycles always precede a rise
  task automatic set_cke(input logic v);
    @(negedge clock);
    cke = v;
    cs_n = 1'b1;
  endtask : set_cke
endmodule : ctl_model

//--- tb.sv
// Purpose: self-checking bench for refresh decode and self-refresh
// Assumes: 125 MHz clock, short residence and recovery counts
// Notes: outputs sampled at the falling edge after each command edge
`timescale 1ns/10ps
`include "refresh_defines.svh"
module tb;
  localparam int unsigned RES = 40;
  localparam int unsigned XSR = 6;
  logic clock;
  logic srst;
  logic hot;
  logic cke, cs_n, cmd_bit0, cmd_bit1, cmd_bit2, cmd_bit3;
  logic all_bank_refresh_cmd, per_bank_refresh_cmd, in_self_refresh;
  logic internal_clock_gate, internal_refresh, exit_recovery, refresh_busy;
  logic [2:0] refresh_bank;
  int bad_count = 0;
  int n_tests = 0;
  // ==================================================
  // clock and instances
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  ctl_model ctl_model_i (.clock(clock), .cke(cke), .cs_n(cs_n), .cmd_bit0(cmd_bit0),
    .cmd_bit1(cmd_bit1), .cmd_bit2(cmd_bit2), .cmd_bit3(cmd_bit3));
  lpddr2_refresh_self_refresh #(.CKESR_CYC(RES), .XSR_CYC(XSR)) lpddr2_refresh_self_refresh_i
    (.clock(clock), .srst(srst), .cke(cke), .cs_n(cs_n), .cmd_bit0(cmd_bit0),
    .cmd_bit1(cmd_bit1), .cmd_bit2(cmd_bit2), .cmd_bit3(cmd_bit3), .hot(hot),
    .all_bank_refresh_cmd(all_bank_refresh_cmd), .per_bank_refresh_cmd(per_bank_refresh_cmd),
    .refresh_bank(refresh_bank), .in_self_refresh(in_self_refresh),
    .internal_clock_gate(internal_clock_gate), .internal_refresh(internal_refresh),
    .exit_recovery(exit_recovery), .refresh_busy(refresh_busy));
  // ==================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // nop cycles, counting falling edges at which the chosen output is high
  // (0 busy, 1 internal refresh, 2 exit recovery)
  task automatic count_hi(input int sel, input int n, output int c);
    c = 0;
    repeat (n)
    begin
      ctl_model_i.idle(1);
      if (sel == 0 && refresh_busy === 1'b1) c++;
      if (sel == 1 && internal_refresh === 1'b1) c++;
      if (sel == 2 && exit_recovery === 1'b1) c++;
    end
  endtask : count_hi
  // one refresh, pulse check, then busy length; the window keeps the spacing too
  task automatic run_ref(input logic b3, input int busy);
    int c;
    int n;
    // no bank is ever opened, and refreshes stay at least 26 cycles apart
    ctl_model_i.issue(1'b1, b3);
    ctl_model_i.idle(1);
    check("all pulse", all_bank_refresh_cmd, b3);
    check("per pulse", per_bank_refresh_cmd, !b3);
    c = (refresh_busy === 1'b1) ? 1 : 0;
    count_hi(0, 24, n);
    check("busy len", c + n, busy);
    check("busy", refresh_busy, 1'b0);
  endtask : run_ref
  // ==================================================
  // scenarios
  task automatic t_reset;
    check("bank", refresh_bank, 3'h0);
    check("self", in_self_refresh, 1'b0);
    check("recov", exit_recovery, 1'b0);
    $display("test reset done");
  endtask : t_reset
  // nine per-bank refreshes wrap the pointer; all-bank zeroes it
  task automatic t_banks;
    // refreshes come far closer than the average interval, over-meeting the count
    for (int i = 0; i < 9; i++)
    begin
      check("bank", refresh_bank, i % 8);
      run_ref(1'b0, `TRFC_PB_CYC);
    end
    check("bank", refresh_bank, 3'h1);
    run_ref(1'b1, `TRFC_AB_CYC);
    check("bank", refresh_bank, 3'h0);
    $display("test banks done");
  endtask : t_banks
  // entry after refreshes, refused early exit, hot internal rate, timed recovery
  task automatic t_self;
    int c;
    run_ref(1'b0, `TRFC_PB_CYC);
    hot = 1'b1;
    ctl_model_i.issue(1'b0, 1'b0);
    ctl_model_i.idle(1);
    check("self", in_self_refresh, 1'b1);
    check("int ref", internal_refresh, 1'b1);
    check("gate", internal_clock_gate, 1'b1);
    // refresh code with cke high: command ignored, exit refused
    ctl_model_i.issue(1'b1, 1'b1);
    ctl_model_i.set_cke(1'b0);
    check("no cmd", all_bank_refresh_cmd, 1'b0);
    check("sr held", in_self_refresh, 1'b1);
    check("no exit", exit_recovery, 1'b0);
    // time in self-refresh stands in for refreshes the bench does not send
    count_hi(1, 300, c);
    check("hot refs", c, 300 / (`TREFI_CYC / 2));
    ctl_model_i.set_cke(1'b1);
    count_hi(2, 20, c);
    check("recov len", c, XSR);
    check("self", in_self_refresh, 1'b0);
    check("bank", refresh_bank, 3'h0);
    $display("test self refresh done");
  endtask : t_self
  // cke low inside recovery re-enters; residence and internal refresh restart
  task automatic t_reentry;
    int c;
    run_ref(1'b1, `TRFC_AB_CYC);
    hot = 1'b0;
    ctl_model_i.issue(1'b0, 1'b0);
    ctl_model_i.idle(1);
    check("self", in_self_refresh, 1'b1);
    count_hi(1, RES, c);
    check("cold refs", c, RES / `TREFI_CYC);
    ctl_model_i.set_cke(1'b1);
    ctl_model_i.idle(2);
    check("recov", exit_recovery, 1'b1);
    ctl_model_i.set_cke(1'b0);
    ctl_model_i.idle(1);
    check("re-entry", in_self_refresh, 1'b1);
    check("re int ref", internal_refresh, 1'b1);
    ctl_model_i.set_cke(1'b1);
    ctl_model_i.idle(1);
    check("re held", in_self_refresh, 1'b1);
    count_hi(2, RES + XSR + 4, c);
    check("recov len", c, XSR);
    check("self", in_self_refresh, 1'b0);
    $display("test re-entry done");
  endtask : t_reentry
  // reset while in self-refresh: back to active, pointer at bank 0
  task automatic t_mid_reset;
    run_ref(1'b1, `TRFC_AB_CYC);
    run_ref(1'b0, `TRFC_PB_CYC);
    check("bank", refresh_bank, 3'h1);
    ctl_model_i.issue(1'b0, 1'b0);
    ctl_model_i.idle(1);
    check("self", in_self_refresh, 1'b1);
    srst = 1'b1;
    ctl_model_i.idle(2);
    srst = 1'b0;
    ctl_model_i.set_cke(1'b1);
    ctl_model_i.idle(1);
    check("self", in_self_refresh, 1'b0);
    check("bank", refresh_bank, 3'h0);
    run_ref(1'b0, `TRFC_PB_CYC);
    check("bank", refresh_bank, 3'h1);
    $display("test mid-run reset done");
  endtask : t_mid_reset
  // ==================================================
  // sequence, watchdog, verdict
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial
  begin
    #(8 * 5000);
    bad_count++;
    end_sim();
  end
  initial
  begin
    srst = 1'b1;
    hot = 1'b0;
    repeat (10) @(negedge clock);
    srst = 1'b0;
    ctl_model_i.set_cke(1'b1);
    ctl_model_i.idle(2);
    t_reset();
    t_banks();
    t_self();
    t_reentry();
    t_mid_reset();
    end_sim();
  end
endmodule : tb
